// >>> common/fsh_pkg.sv
// Purpose: Shared constants and stream word helpers for the FEC sync header
//          transmit end and its receiving partner.
// Assumes: One 66-bit block per valid cycle; stream bit 0 sent first.
// Notes:   Stream words are indexed by position, bit 0 = first block.
`default_nettype none

package fsh_pkg;

  // ---------------------------------------------------------------------
  // Framing
  // ---------------------------------------------------------------------
  localparam int BLK_W   = 64;
  localparam int MB_BLKS = 32;
  localparam int POS_W   = 5;
  localparam logic [POS_W-1:0] POS_LAST = 5'h1f;

  // Two-bit sync header, element [0] is sent first
  localparam logic [0:1] HDR_ONE  = 2'h1;
  localparam logic [0:1] HDR_ZERO = 2'h2;

  // ---------------------------------------------------------------------
  // Modes and parity
  // ---------------------------------------------------------------------
  localparam logic [1:0] MODE_CRC = 2'h0;
  localparam logic [1:0] MODE_FEC = 2'h2;
  localparam int FEC_W = 26;
  localparam int CRC_W = 12;
  // Feedback taps, top term implied
  localparam logic [FEC_W-1:0] FEC_POLY = 26'h0220211;
  localparam logic [CRC_W-1:0] CRC_POLY = 12'h30f;

  // ---------------------------------------------------------------------
  // Stream word layout
  // ---------------------------------------------------------------------
  localparam int EXT_END_BIT = 22;
  localparam int FEC_P3_BIT = 23;
  localparam int PILOT_LSB = 27;
  // Positions 27..31 carry 0,0,0,0,1
  localparam logic [4:0] PILOT_FIELD = 5'h10;

  // ---------------------------------------------------------------------
  // Receiver registers (APB byte offsets and fields)
  // ---------------------------------------------------------------------
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STAT = 12'h004;
  localparam logic [11:0] REG_SYND = 12'h008;
  localparam logic [11:0] REG_ERRC = 12'h00c;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam int CTRL_EN  = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_DELAY_LSB = 8;

  function automatic logic [31:0] fec_word(input logic [FEC_W-1:0] p,
                                           input logic eo);
    logic [31:0] w;
    w = '0;
    for (int i = 0; i < 22; i++) w[i] = p[25-i];
    w[EXT_END_BIT] = eo;
    w[FEC_P3_BIT] = p[3];
    for (int k = 0; k < 3; k++) w[24+k] = p[2-k];
    w[31:PILOT_LSB] = PILOT_FIELD;
    return w;
  endfunction : fec_word

  function automatic logic [FEC_W-1:0] fec_take(input logic [31:0] w);
    logic [FEC_W-1:0] p;
    p = '0;
    for (int i = 0; i < 22; i++) p[25-i] = w[i];
    p[3] = w[FEC_P3_BIT];
    for (int k = 0; k < 3; k++) p[2-k] = w[24+k];
    return p;
  endfunction : fec_take

  // Groups of three parity bits then a fixed one; command bits are zero
  function automatic logic [31:0] crc_word(input logic [CRC_W-1:0] c,
                                           input logic eo);
    logic [31:0] w;
    w = '0;
    for (int g = 0; g < 4; g++) begin
      for (int j = 0; j < 3; j++) w[4*g+j] = c[11-3*g-j];
      w[4*g+3] = 1'b1;
    end
    w[19] = 1'b1;
    w[21] = 1'b1;
    w[23] = 1'b1;
    w[EXT_END_BIT] = eo;
    w[31:PILOT_LSB] = PILOT_FIELD;
    return w;
  endfunction : crc_word

endpackage : fsh_pkg

`default_nettype wire

// >>> common/fsh_link_if.sv
// Purpose: Block-parallel lane between transmit end and receiving end.
// Assumes: Both ends on core_clk; one block per cycle with blk_valid.
// Notes:   emphasis stands in for the analog serializer setting.
`default_nettype none
`timescale 1ns/1ps

interface fsh_link_if;
  logic        blk_valid;
  logic [0:1]  sync_hdr;
  logic [63:0] payload;
  logic [3:0]  emphasis;

  modport tx (output blk_valid, output sync_hdr, output payload,
              output emphasis);
  modport rx (input blk_valid, input sync_hdr, input payload,
              input emphasis);
endinterface : fsh_link_if

`default_nettype wire

// >>> hw/fsh_par_div.sv
// Purpose: Polynomial divider over one multiblock of payload, one whole block per cycle.
// Assumes: first/last mark the first and last block of a multiblock.
// Notes:   par holds the result of the last completed multiblock.
`default_nettype none
`timescale 1ns/1ps

module fsh_par_div #(
  parameter int             W    = 26,
  parameter logic [W-1:0]   POLY = '0,
  parameter int             DW   = 64
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rstn,
  // Block input
  input  wire logic          en,
  input  wire logic          first,
  input  wire logic          last,
  input  wire logic [DW-1:0] data,
  // Result
  output logic      [W-1:0]  par
);

  logic [W-1:0] acc_ff;
  logic [W-1:0] par_ff;
  logic [W-1:0] nxt_acc;

  // Oldest bit first, one shift per payload bit
  always_comb begin
    logic fb;
    fb = 1'b0;
    nxt_acc = first ? '0 : acc_ff;
    for (int i = DW-1; i >= 0; i--) begin
      fb = data[i] ^ nxt_acc[W-1];
      nxt_acc = {nxt_acc[W-2:0], 1'b0} ^ (fb ? POLY : '0);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      acc_ff <= '0;
      par_ff <= '0;
    end else if (en) begin
      acc_ff <= nxt_acc;
      if (last) par_ff <= nxt_acc;
    end
  end

  assign par = par_ff;

endmodule : fsh_par_div

`default_nettype wire

// >>> hw/fsh_tx_end.sv
// Purpose: Transmit end: sync header stream with FEC or CRC parity,
//          pilot and extended multiblock end flag.
// Assumes: payload_in is already scrambled; sysref arrives from a pin.
// Notes:   Mode is sampled only while the link is disabled.
`default_nettype none
`timescale 1ns/1ps

module fsh_tx_end #(
  parameter int MB_PER_EMB = 1,
  parameter int EMPH_W     = 4
) (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rstn,
  // Configuration
  input  wire logic                    link_enable_bit,
  input  wire logic [1:0]              sync_header_mode_select,
  input  wire logic [EMPH_W-1:0]       serializer_emphasis_level,
  // Timing reference pin
  input  wire logic                    sysref,
  // Scrambled payload from the transport side
  input  wire logic                    blk_valid_in,
  input  wire logic [63:0]             payload_in,
  // Status
  output logic                         link_active,
  // Lane
  fsh_link_if.tx                       link
);

  localparam int MB_CW = (MB_PER_EMB > 1) ? $clog2(MB_PER_EMB) : 1;
  localparam logic [MB_CW-1:0] MB_END = MB_CW'(MB_PER_EMB - 1);

  // -----------------------------------------------------------------------
  // SYSREF synchroniser and edge
  // -----------------------------------------------------------------------
  logic sref_meta_ff;
  logic sref_sync_ff;
  logic sref_prev_ff;
  logic sref_rise;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sref_meta_ff <= 1'b0;
      sref_sync_ff <= 1'b0;
      sref_prev_ff <= 1'b0;
    end else begin
      sref_meta_ff <= sysref;
      sref_sync_ff <= sref_meta_ff;
      sref_prev_ff <= sref_sync_ff;
    end
  end

  assign sref_rise = sref_sync_ff & ~sref_prev_ff;

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  logic [1:0]                mode_ff;
  logic [fsh_pkg::POS_W-1:0] blk_cnt_ff;
  logic [MB_CW-1:0]          mb_cnt_ff;
  logic                      par_ok_ff;
  logic                      realign_ff;
  logic [31:0]               word_ff;
  logic                      valid_ff;
  logic [0:1]                hdr_ff;
  logic [63:0]               data_ff;
  logic [EMPH_W-1:0]         emph_ff;
  logic                      active_ff;

  logic                      step;
  logic                      mb_first;
  logic                      mb_last;
  logic                      is_fec;
  logic                      emb_end;
  logic [fsh_pkg::FEC_W-1:0] fec_par;
  logic [fsh_pkg::CRC_W-1:0] crc_par;
  logic [fsh_pkg::FEC_W-1:0] fec_use;
  logic [fsh_pkg::CRC_W-1:0] crc_use;
  logic [31:0]               new_word;
  logic [31:0]               cur_word;
  logic                      sh_bit;
  logic [0:1]                nxt_hdr;

  assign step     = blk_valid_in & link_enable_bit;
  assign mb_first = (blk_cnt_ff == '0);
  assign mb_last  = (blk_cnt_ff == fsh_pkg::POS_LAST);
  assign is_fec   = (mode_ff == fsh_pkg::MODE_FEC);
  assign emb_end  = (mb_cnt_ff == MB_END);

  // -----------------------------------------------------------------------
  // Parity dividers
  // -----------------------------------------------------------------------
  // Both run on every multiblock so a mode change needs no warm-up
  fsh_par_div #(
    .W    (fsh_pkg::FEC_W),
    .POLY (fsh_pkg::FEC_POLY),
    .DW   (fsh_pkg::BLK_W)
  ) u_fec_div (
    .core_clk (core_clk),
    .rstn     (rstn),
    .en       (step),
    .first    (mb_first),
    .last     (mb_last),
    .data     (payload_in),
    .par      (fec_par)
  );

  fsh_par_div #(
    .W    (fsh_pkg::CRC_W),
    .POLY (fsh_pkg::CRC_POLY),
    .DW   (fsh_pkg::BLK_W)
  ) u_crc_div (
    .core_clk (core_clk),
    .rstn     (rstn),
    .en       (step),
    .first    (mb_first),
    .last     (mb_last),
    .data     (payload_in),
    .par      (crc_par)
  );

  // -----------------------------------------------------------------------
  // Stream word
  // -----------------------------------------------------------------------
  // Divider output holds the previous multiblock's result here
  assign fec_use  = par_ok_ff ? fec_par : '0;
  assign crc_use  = par_ok_ff ? crc_par : '0;
  assign new_word = is_fec ? fsh_pkg::fec_word(fec_use, emb_end)
                           : fsh_pkg::crc_word(crc_use, emb_end);
  assign cur_word = mb_first ? new_word : word_ff;
  assign sh_bit   = cur_word[blk_cnt_ff];
  assign nxt_hdr  = sh_bit ? fsh_pkg::HDR_ONE : fsh_pkg::HDR_ZERO;

  // -----------------------------------------------------------------------
  // Counters and framing
  // -----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mode_ff     <= fsh_pkg::MODE_CRC;
      blk_cnt_ff  <= '0;
      mb_cnt_ff   <= '0;
      par_ok_ff   <= 1'b0;
      realign_ff  <= 1'b0;
      word_ff     <= '0;
    end else if (!link_enable_bit) begin
      // Held in reset; mode only taken while stopped
      mode_ff     <= sync_header_mode_select;
      blk_cnt_ff  <= '0;
      mb_cnt_ff   <= '0;
      par_ok_ff   <= 1'b0;
      realign_ff  <= 1'b0;
    end else begin
      if (sref_rise) realign_ff <= 1'b1;
      if (step) begin
        blk_cnt_ff <= fsh_pkg::POS_W'(blk_cnt_ff + 1'b1);
        if (mb_first) word_ff <= new_word;
        if (mb_last) begin
          par_ok_ff <= 1'b1;
          // Realign on a boundary so no multiblock is cut short
          if (realign_ff || sref_rise || emb_end) begin
            mb_cnt_ff   <= '0;
            realign_ff  <= 1'b0;
          end else begin
            mb_cnt_ff <= MB_CW'(mb_cnt_ff + 1'b1);
          end
        end
      end
    end
  end

  // -----------------------------------------------------------------------
  // Lane outputs
  // -----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      valid_ff  <= 1'b0;
      hdr_ff    <= fsh_pkg::HDR_ZERO;
      data_ff   <= '0;
      emph_ff   <= '0;
      active_ff <= 1'b0;
    end else begin
      valid_ff  <= step;
      active_ff <= link_enable_bit;
      emph_ff   <= serializer_emphasis_level;
      if (step) begin
        hdr_ff  <= nxt_hdr;
        data_ff <= payload_in;
      end
    end
  end

  assign link.blk_valid = valid_ff;
  assign link.sync_hdr  = hdr_ff;
  assign link.payload   = data_ff;
  assign link.emphasis  = emph_ff;
  assign link_active    = active_ff;

endmodule : fsh_tx_end

`default_nettype wire

// >>> hw/fsh_rx_end.sv
// Purpose: Receiving end: lock monitors, FEC syndrome and buffer release,
//          controlled over APB.
// Assumes: Lane and local_ext_multiblock_clock are on core_clk; one lane.
// Notes:   Syndrome is reported, not used to correct data.
`default_nettype none
`timescale 1ns/1ps

module fsh_rx_end #(
  parameter int MB_PER_EMB  = 1,
  parameter int SH_WIN_W    = 6,
  parameter int SH_ERR_MAX  = 4,
  parameter int MB_CONFIRM  = 4,
  parameter int MB_ERR_MAX  = 4,
  parameter int EMB_ERR_MAX = 3
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Timing reference and user side
  input  wire logic        local_ext_multiblock_clock,
  output logic             sysref_request,
  output logic             rx_valid,
  output logic      [63:0] rx_data,
  // Lane
  fsh_link_if.rx           link
);

  localparam int MB_CW = (MB_PER_EMB > 1) ? $clog2(MB_PER_EMB) : 1;
  localparam logic [MB_CW-1:0] MB_END = MB_CW'(MB_PER_EMB - 1);

  logic [15:0] ctrl_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff, pslverr_ff;
  logic        blk_lock_ff, mb_lock_ff, emb_lock_ff, par_ok_ff;
  logic        buf_ff, released_ff, armed_ff, sref_req_ff;
  logic [SH_WIN_W-1:0] bwin_ff;
  logic [7:0]  berr_ff, merr_ff, eerr_ff, hits_ff, rcnt_ff;
  logic [fsh_pkg::POS_W-1:0] pos_ff;
  logic [MB_CW-1:0] emb_cnt_ff;
  logic [31:0] sr_ff;
  logic [25:0] synd_ff;
  logic [15:0] errc_ff;
  logic        rxv_ff;
  logic [63:0] rxd_ff;

  // -----------------------------------------------------------------------
  // APB decode
  // -----------------------------------------------------------------------
  wire        en_on   = ctrl_ff[fsh_pkg::CTRL_EN];
  wire [1:0]  mode    = ctrl_ff[fsh_pkg::CTRL_MODE_LSB +: 2];
  wire [7:0]  buffer_release_delay = ctrl_ff[fsh_pkg::CTRL_DELAY_LSB +: 8];
  wire        setup   = psel & ~penable;
  wire        hit_c   = (paddr == fsh_pkg::REG_CTRL);
  wire        hit_s   = (paddr == fsh_pkg::REG_STAT);
  wire        hit_y   = (paddr == fsh_pkg::REG_SYND);
  wire        hit_e   = (paddr == fsh_pkg::REG_ERRC);
  wire        hit_any = hit_c | hit_s | hit_y | hit_e;
  wire        wr_c    = psel & penable & pwrite & pready_ff & hit_c;
  wire [31:0] stat_w  = {26'h0, sref_req_ff, released_ff, emb_lock_ff,
                         mb_lock_ff, blk_lock_ff, buf_ff};
  wire [31:0] rd_mux  = hit_c ? {16'h0, ctrl_ff} :
                        hit_s ? stat_w :
                        hit_y ? {6'h0, synd_ff} :
                        hit_e ? {16'h0, errc_ff} : 32'h0;

  // Parameters frozen while enabled; only the enable bit then writes
  wire [15:0] nxt_ctrl = en_on ? {ctrl_ff[15:1], pwdata[0]}
                               : pwdata[15:0];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff    <= fsh_pkg::CTRL_RST;
      prdata_ff  <= '0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~hit_any;
      prdata_ff  <= (setup & ~pwrite) ? rd_mux : 32'h0;
      if (wr_c) ctrl_ff <= nxt_ctrl;
    end
  end

  // -----------------------------------------------------------------------
  // Lane decode
  // -----------------------------------------------------------------------
  wire        v       = link.blk_valid & en_on;
  wire        sh_bad  = (link.sync_hdr[0] == link.sync_hdr[1]);
  wire        sh_bit  = (link.sync_hdr == fsh_pkg::HDR_ONE);
  wire [31:0] sr_now  = {sr_ff[30:0], sh_bit};
  wire [31:0] word    = {<<{sr_now}};
  wire        pilot   = (word[31:fsh_pkg::PILOT_LSB] == fsh_pkg::PILOT_FIELD);
  wire        eo      = word[fsh_pkg::EXT_END_BIT];
  wire [fsh_pkg::POS_W-1:0] cur = fsh_pkg::POS_W'(pos_ff + 1'b1);
  wire        mb_end  = mb_lock_ff & (cur == fsh_pkg::POS_LAST);
  wire        cand    = (hits_ff != 8'h0);
  wire        at_cand = cand & (cur == fsh_pkg::POS_LAST);
  wire        exp_eo  = (emb_cnt_ff == MB_END);
  wire        win_end = &bwin_ff;
  wire [7:0]  berr_n  = 8'(berr_ff + {7'h0, sh_bad});
  wire [25:0] rx_par;
  // Previous multiblock's parity against the one carried now
  wire [25:0] synd    = rx_par ^ fsh_pkg::fec_take(word);

  fsh_par_div #(
    .W    (fsh_pkg::FEC_W),
    .POLY (fsh_pkg::FEC_POLY),
    .DW   (fsh_pkg::BLK_W)
  ) u_chk_div (
    .core_clk (core_clk),
    .rstn     (rstn),
    .en       (v & mb_lock_ff),
    .first    (cur == '0),
    .last     (cur == fsh_pkg::POS_LAST),
    .data     (link.payload),
    .par      (rx_par)
  );

  // -----------------------------------------------------------------------
  // Lock monitors, syndrome and release
  // -----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      {blk_lock_ff, mb_lock_ff, emb_lock_ff, par_ok_ff} <= '0;
      {buf_ff, released_ff, armed_ff, sref_req_ff} <= '0;
      {bwin_ff, berr_ff, merr_ff, eerr_ff, hits_ff, rcnt_ff} <= '0;
      {pos_ff, emb_cnt_ff, sr_ff, synd_ff, errc_ff} <= '0;
    end else if (!en_on) begin
      {blk_lock_ff, mb_lock_ff, emb_lock_ff, par_ok_ff} <= '0;
      {buf_ff, released_ff, armed_ff} <= '0;
      {bwin_ff, berr_ff, hits_ff} <= '0;
      errc_ff <= '0;
    end else begin
      if (v) begin
        sr_ff   <= sr_now;
        bwin_ff <= SH_WIN_W'(bwin_ff + 1'b1);
        berr_ff <= win_end ? 8'h0 : berr_n;
        // A lone bad header is absorbed; SH_ERR_MAX or more in a window drop lock
        if (win_end) blk_lock_ff <= (berr_n < 8'(SH_ERR_MAX));
        if (!blk_lock_ff) begin
          {mb_lock_ff, emb_lock_ff, par_ok_ff, buf_ff, released_ff} <= '0;
          hits_ff <= '0;
        end else if (!mb_lock_ff) begin
          // One candidate at a time; chance pilot patterns in parity
          // bits elsewhere must not restart a good count
          pos_ff <= (pilot && !cand) ? fsh_pkg::POS_LAST : cur;
          if (at_cand) hits_ff <= pilot ? 8'(hits_ff + 1'b1) : 8'h0;
          else if (pilot && !cand) hits_ff <= 8'h1;
          if (at_cand && pilot && hits_ff >= 8'(MB_CONFIRM - 1))
            mb_lock_ff <= 1'b1;
          merr_ff <= '0;
        end else begin
          pos_ff <= cur;
          if (mb_end) begin
            par_ok_ff <= 1'b1;
            if (par_ok_ff && mode == fsh_pkg::MODE_FEC) begin
              synd_ff <= synd;
              if (synd != '0) errc_ff <= 16'(errc_ff + 1'b1);
            end
            merr_ff <= pilot ? 8'h0 : 8'(merr_ff + 1'b1);
            if (!pilot && merr_ff >= 8'(MB_ERR_MAX - 1)) begin
              {mb_lock_ff, emb_lock_ff, par_ok_ff} <= '0;
              {buf_ff, released_ff, hits_ff} <= '0;
            end
            if (!emb_lock_ff) begin
              if (eo) {emb_lock_ff, sref_req_ff} <= 2'h2;
              emb_cnt_ff <= '0;
              eerr_ff    <= '0;
            end else begin
              emb_cnt_ff <= exp_eo ? '0 : MB_CW'(emb_cnt_ff + 1'b1);
              eerr_ff <= (eo == exp_eo) ? 8'h0 : 8'(eerr_ff + 1'b1);
              if (eo != exp_eo && eerr_ff >= 8'(EMB_ERR_MAX - 1)) begin
                {emb_lock_ff, sref_req_ff} <= 2'h1;
                {buf_ff, released_ff} <= '0;
              end else if (exp_eo) begin
                buf_ff <= 1'b1;
              end
            end
          end
        end
      end
      // Release point offset from the local timing edge
      if (local_ext_multiblock_clock) begin
        armed_ff <= 1'b1;
        rcnt_ff  <= '0;
      end else if (armed_ff) begin
        if (rcnt_ff == buffer_release_delay) begin
          armed_ff <= 1'b0;
          if (buf_ff) released_ff <= 1'b1;
        end else begin
          rcnt_ff <= 8'(rcnt_ff + 1'b1);
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rxv_ff <= 1'b0;
      rxd_ff <= '0;
    end else begin
      rxv_ff <= v & released_ff;
      if (v) rxd_ff <= link.payload;
    end
  end

  assign prdata         = prdata_ff;
  assign pready         = pready_ff;
  assign pslverr        = pslverr_ff;
  assign sysref_request = sref_req_ff;
  assign rx_valid       = rxv_ff;
  assign rx_data        = rxd_ff;

endmodule : fsh_rx_end

`default_nettype wire

// >>> tb/fsh_asserts.sv
// Purpose: Lane assertions between the transmit and receive ends.
// Assumes: Link enabled once per reset; sysref idle.
// Notes:   Counters restart on reset, as the framing does.
`default_nettype none
`timescale 1ns/1ps
module fsh_asserts #(parameter int MB_PER_EMB = 2) (
  // Lane
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        blk_valid,
  input wire logic [0:1]  sync_hdr,
  input wire logic [63:0] payload
);
  logic [4:0] pos_ff;
  int         mb_ff;
  wire logic  last_mb = (mb_ff == MB_PER_EMB - 1);
  wire logic  at_end = blk_valid && (pos_ff == 5'h1f);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pos_ff <= 5'h0;
      mb_ff <= 0;
    end else if (blk_valid) begin
      pos_ff <= pos_ff + 5'h1;
      if (at_end)
        mb_ff <= last_mb ? 0 : mb_ff + 1;
    end
  end
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rstn);
  chk_hdr_legal: assert property (blk_valid |-> ^sync_hdr)
    else $error("sync header not 01 or 10");
  chk_pilot_zero: assert property (blk_valid && pos_ff inside {[27:30]}
    |-> sync_hdr == fsh_pkg::HDR_ZERO)
    else $error("pilot zero bit wrong");
  chk_pilot_one: assert property (at_end
    |-> sync_hdr == fsh_pkg::HDR_ONE)
    else $error("pilot final bit wrong");
  chk_emb_set: assert property (blk_valid && pos_ff == 5'h16 && last_mb
    |-> sync_hdr == fsh_pkg::HDR_ONE)
    else $error("end flag missing");
  chk_emb_clear: assert property (blk_valid && pos_ff == 5'h16 && !last_mb
    |-> sync_hdr == fsh_pkg::HDR_ZERO)
    else $error("end flag set early");
  chk_hdr_hold: assert property (!blk_valid |-> $stable(sync_hdr))
    else $error("header moved while idle");
  chk_data_hold: assert property (!blk_valid |-> $stable(payload))
    else $error("payload moved while idle");
  // No block may leave in the cycle that reset is released
  chk_reset_idle: assert property ($rose(rstn) |-> !blk_valid)
    else $error("block sent at reset release");
endmodule : fsh_asserts
`default_nettype wire

// >>> tb/fec_sync_header_stream_bench.sv
// Purpose: Both ends joined; stream words and receiver registers checked.
// Assumes: Parity model here is independent of the package helpers.
// Notes:   Every seventh cycle idles to exercise hold behaviour.
`default_nettype none
`timescale 1ns/1ps
module fec_sync_header_stream_bench;
  logic        core_clk, rstn, link_enable_bit, sysref, blk_valid_in;
  logic        emb_tick, psel, penable, pwrite, pready, pslverr, e, act, fm;
  logic [1:0]  sync_header_mode_select;
  logic [3:0]  serializer_emphasis_level;
  logic [63:0] payload_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, word, r, msk, xw;
  logic [25:0] cur, prv;
  logic [5:0]  lc;
  int          err_total, check_count, pos, mbn;
  fsh_link_if link ();
  fsh_tx_end #(.MB_PER_EMB(2)) fsh_tx_end_inst (.core_clk, .rstn,
    .link_enable_bit, .sync_header_mode_select, .serializer_emphasis_level,
    .sysref, .blk_valid_in, .payload_in, .link_active(act), .link);
  fsh_rx_end #(.MB_PER_EMB(2)) fsh_rx_end_inst (.core_clk, .rstn, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .local_ext_multiblock_clock(emb_tick), .sysref_request(), .rx_valid(),
    .rx_data(), .link);
  fsh_asserts #(.MB_PER_EMB(2)) fsh_asserts_inst (.core_clk, .rstn,
    .blk_valid(link.blk_valid), .sync_hdr(link.sync_hdr),
    .payload(link.payload));
  function automatic logic [25:0] div(logic [25:0] s, logic [63:0] d);
    for (int i = 63; i >= 0; i--)
      s = {s[24:0], 1'b0} ^ ((s[25] ^ d[i]) ? fsh_pkg::FEC_POLY : 26'h0);
    return s;
  endfunction : div
  function automatic logic [31:0] fw(logic [25:0] p, logic eo);
    fw = {5'h10, p[0], p[1], p[2], p[3], eo, 22'h0};
    for (int i = 0; i < 22; i++) fw[i] = p[25 - i];
  endfunction : fw
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    check_count++;
    if (g !== x) begin
      err_total++;
      $display("mismatch %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    {r, e} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    if (pready !== 1'b1) begin
      err_total++;
      summarize();
    end
  endtask : apb
  task automatic start(logic [1:0] m);
    @(posedge core_clk);
    {rstn, link_enable_bit, sync_header_mode_select} <= {2'h0, m};
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    {pos, mbn, cur, prv} = '0;
    // CRC words: fixed fields only, parity bits are not modelled
    fm = (m == fsh_pkg::MODE_FEC);
    msk = fm ? 32'hffffffff : 32'hffff8888;
    @(posedge core_clk);
    link_enable_bit <= 1'b1;
  endtask : start
  task automatic run(int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      blk_valid_in <= (i % 7 != 6);
      payload_in <= {i, ~i} ^ 64'h5a5a_0000_c3c3_0000;
    end
    @(posedge core_clk);
    blk_valid_in <= 1'b0;
  endtask : run
  task automatic fec_run();
    start(2'h2);
    apb(1'b1, fsh_pkg::REG_CTRL, 32'h5);
    apb(1'b1, fsh_pkg::REG_CTRL, 32'h1);
    apb(1'b0, fsh_pkg::REG_CTRL, 32'h0);
    chk("ctrl", 32'h5, r);
    run(1200);
    apb(1'b0, fsh_pkg::REG_STAT, 32'h0);
    chk("status", 32'h1f, {26'h0, r[5:0]});
    apb(1'b0, fsh_pkg::REG_SYND, 32'h0);
    chk("syndrome", 32'h0, r);
    apb(1'b0, fsh_pkg::REG_ERRC, 32'h0);
    chk("err count", 32'h0, r);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
  endtask : fec_run
  task automatic emph_run();
    @(posedge core_clk);
    serializer_emphasis_level <= 4'h9;
    repeat (3) @(posedge core_clk);
    chk("emphasis", 32'h9, {28'h0, link.emphasis});
    chk("active", 32'h1, {31'h0, act});
  endtask : emph_run
  task automatic crc_run();
    start(2'h0);
    run(200);
  endtask : crc_run
  always @(posedge core_clk) begin
    emb_tick <= (lc == 6'h0);
    lc <= lc + 6'h1;
    if (link.blk_valid) begin
      word[pos] = (link.sync_hdr === 2'h1);
      cur = div(cur, link.payload);
      if (pos == 31) begin
        xw = fm ? fw(prv, mbn[0]) : {9'h101, mbn[0], 22'h288888};
        chk("stream", xw & msk, word & msk);
        {prv, cur} = {cur, 26'h0};
        mbn++;
      end
      pos = (pos + 1) % 32;
    end
  end
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    {rstn, link_enable_bit, sync_header_mode_select, sysref, blk_valid_in,
     serializer_emphasis_level, payload_in, paddr, psel, penable, pwrite,
     pwdata, emb_tick, lc} = '0;
    fec_run();
    crc_run();
    emph_run();
    summarize();
  end
endmodule : fec_sync_header_stream_bench
`default_nettype wire
